// ### logic/itpsc_pkg.sv
// constants, states and the function list for the interlace-to-progressive sync control
// Function
// - after reset the block passes input video straight to the output with no memory access.
// - in pass-through only active picture samples reach the output, blanking is dropped.
// - when either stream cannot move data the block stalls instead of dropping samples.
// - an output overrun is flagged when the consumer stalls the output past 1000 cycles.
// - an input overrun is flagged when the input buffer fills because the output drains too slowly.
// - software sets raster size and method, then requests a start taken at the next frame boundary.
// - on frame sync the block raises its sync pin, an event pulse and a readable sync status.
// - while deinterlacing each input pixel yields two output pixels.
// - loss of sync is entered on a raster size mismatch, a full input buffer or an output overrun.
// - the evaluation build times out after about eight hours and forces its video output to zero.
// - motion-adaptive mode enables the memory port only at the next frame boundary seen while in sync.
// - write overflow and underflow of either read stream are told apart as three errors.
// - enable bits 11, 10 and 9 gate reporting of the three memory errors onto status bits.
package itpsc_pkg;
   localparam int  CLK_MHZ          = 100;
   localparam int  OUT_STALL_LIMIT  = 1000;
   localparam int  EVAL_HOURS       = 8;
   localparam longint EVAL_CYCLES   = longint'(EVAL_HOURS) * 3600 * CLK_MHZ * 1000000;
   localparam int  FIFO_DEPTH       = 4;
   localparam int  DIM_W            = 12;
   // error status bit positions
   localparam int  ERR_IN_OVR       = 0;
   localparam int  ERR_OUT_OVR      = 1;
   localparam int  ERR_LOS          = 2;
   localparam int  ERR_WR_OVF       = 9;
   localparam int  ERR_RD0_UDF      = 10;
   localparam int  ERR_RD1_UDF      = 11;
   localparam int  ERR_W            = 12;
   localparam logic [ERR_W-1:0] ERR_RESET = 12'h000;
   typedef enum logic [1:0] {
      ITPSC_PASS = 2'b00,
      ITPSC_ARM  = 2'b01,
      ITPSC_SYNC = 2'b11,
      ITPSC_LOS  = 2'b10
   } itpsc_state_e;
endpackage

// ### logic/itpsc_fifo.sv
// small flip-flop fifo with valid/ready on both sides
module itpsc_fifo
   import itpsc_pkg::*;
#(
   parameter int WIDTH = 24,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  full
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // handshake terms; no push when full so nothing is lost
   assign push      = in_valid && (count != (AW+1)'(DEPTH));
   assign pop       = out_valid && out_ready;
   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign full      = (count == (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   // storage write
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### logic/itpsc_timer.sv
// saturating stall / lifetime counter with a terminal flag
module itpsc_timer #(
   parameter int     W     = 16,
   parameter longint LIMIT = 1000
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic run,
   input  wire logic clear,
   output logic      expired
);
   logic [W-1:0] count;

   // counts while run, holds one past the limit; expired once count exceeds limit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count   <= '0;
         expired <= 1'b0;
      end else if (clear) begin
         count   <= '0;
         expired <= 1'b0;
      end else if (run && !expired) begin
         count <= count + 1'b1;
         if (count >= W'(LIMIT)) begin
            expired <= 1'b1;
         end
      end
   end
endmodule

// ### logic/itpsc_top.sv
// sync control: pass-through, frame-boundary start, rate doubling and error flags
module itpsc_top
   import itpsc_pkg::*;
#(
   parameter int     DATA_W      = 24,
   parameter int     DEPTH       = FIFO_DEPTH,
   parameter bit     EVAL_BUILD  = 1'b0,
   parameter longint EVAL_LIMIT  = EVAL_CYCLES
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   // input video stream
   input  wire logic [DATA_W-1:0] s_tdata,
   input  wire logic              s_tvalid,
   input  wire logic              s_tuser,
   input  wire logic              s_tlast,
   input  wire logic              s_active,
   output logic                   s_tready,
   // output video stream
   output logic      [DATA_W-1:0] m_tdata,
   output logic                   m_tvalid,
   output logic                   m_tuser,
   output logic                   m_tlast,
   input  wire logic              m_tready,
   // control from the register file
   input  wire logic [DIM_W-1:0]  cfg_width,
   input  wire logic [DIM_W-1:0]  cfg_height,
   input  wire logic              cfg_motion,
   input  wire logic              cfg_start,
   input  wire logic [ERR_W-1:0]  cfg_irq_en,
   input  wire logic [ERR_W-1:0]  err_clear,
   // memory-side error events
   input  wire logic              mem_wr_ovf,
   input  wire logic              mem_rd0_udf,
   input  wire logic              mem_rd1_udf,
   // status
   output logic                   sync_pin,
   output logic                   sync_status,
   output logic                   sync_event,
   output logic                   mem_port_en,
   output logic      [ERR_W-1:0]  err_status,
   output logic                   irq
);
   itpsc_state_e   state;
   logic           start_pend;
   logic           motion_pend;
   logic           frame_start;
   logic           in_push;
   logic           fifo_in_ready;
   logic           fifo_out_valid;
   logic           fifo_full;
   logic [DATA_W+1:0] fifo_out;
   logic           dbl_phase;
   logic           take;
   logic           out_stalled;
   logic           out_ovr;
   logic           eval_dead;
   logic [DIM_W-1:0] col_cnt;
   logic [DIM_W-1:0] row_cnt;
   logic           dim_bad;
   logic [ERR_W-1:0] err_set;
   // bookkeeping shared by the raster check, the sequencer and the flags
   logic           in_taken;
   logic [DIM_W-1:0] line_len;
   logic           sync_hit;
   logic           lose_sync;
   logic [ERR_W-1:0] next_err_status;

   // only active samples enter the buffer; blanking is dropped
   assign in_push     = s_tvalid && s_active;
   assign s_tready    = fifo_in_ready || !s_active;
   assign in_taken    = in_push && fifo_in_ready;
   assign frame_start = in_taken && s_tuser;

   itpsc_fifo #(
      .WIDTH (DATA_W + 2),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (in_push),
      .in_ready  (fifo_in_ready),
      .in_data   ({s_tuser, s_tlast, s_tdata}),
      .out_valid (fifo_out_valid),
      .out_ready (take),
      .out_data  (fifo_out),
      .full      (fifo_full)
   );

   // output register free when empty or being taken
   logic out_free;
   assign out_free = !m_tvalid || m_tready;
   // in sync each word goes out twice before the buffer advances
   assign take = fifo_out_valid && out_free && (state != ITPSC_SYNC || dbl_phase);

   // output stage; stalls rather than drops when downstream is not ready
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         m_tdata   <= '0;
         m_tvalid  <= 1'b0;
         m_tuser   <= 1'b0;
         m_tlast   <= 1'b0;
         dbl_phase <= 1'b0;
      end else if (out_free) begin
         m_tvalid <= fifo_out_valid;
         m_tdata  <= eval_dead ? '0 : fifo_out[DATA_W-1:0];
         m_tuser  <= fifo_out[DATA_W+1] && !dbl_phase;
         m_tlast  <= fifo_out[DATA_W] && (state != ITPSC_SYNC || dbl_phase);
         if (fifo_out_valid && state == ITPSC_SYNC) begin
            dbl_phase <= !dbl_phase;
         end else begin
            dbl_phase <= 1'b0;
         end
      end
   end

   // output stall watchdog
   assign out_stalled = m_tvalid && !m_tready;
   itpsc_timer #(
      .W     (11),
      .LIMIT (OUT_STALL_LIMIT)
   ) u_stall (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (out_stalled),
      .clear   (!out_stalled),
      .expired (out_ovr)
   );

   // lifetime counter for the evaluation build
   logic eval_exp;
   itpsc_timer #(
      .W     (48),
      .LIMIT (EVAL_LIMIT)
   ) u_eval (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (EVAL_BUILD),
      .clear   (1'b0),
      .expired (eval_exp)
   );
   assign eval_dead = EVAL_BUILD && eval_exp;

   // raster position of the incoming active samples
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         col_cnt <= '0;
         row_cnt <= '0;
      end else if (in_taken) begin
         if (s_tlast) begin
            col_cnt <= '0;
            row_cnt <= (s_tuser ? '0 : row_cnt) + 1'b1;
         end else if (s_tuser) begin
            col_cnt <= DIM_W'(1);
            row_cnt <= '0;
         end else begin
            col_cnt <= col_cnt + 1'b1;
         end
      end
   end

   // length of the line that the current sample closes
   assign line_len = s_tuser ? DIM_W'(1) : col_cnt + 1'b1;

   // size mismatch pulse; frame height is judged only once in sync, so a
   // partial frame seen before the start cannot knock the fresh sync down
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dim_bad <= 1'b0;
      end else if (in_taken && s_tlast && (line_len != cfg_width)) begin
         dim_bad <= 1'b1;
      end else if (in_taken && s_tuser && (state == ITPSC_SYNC)) begin
         dim_bad <= (row_cnt != cfg_height);
      end else begin
         dim_bad <= 1'b0;
      end
   end

   // sync is won on a frame's first sample, lost on a size fault, a full buffer or an output overrun
   assign sync_hit  = (state == ITPSC_ARM) && frame_start;
   assign lose_sync = (state == ITPSC_SYNC) && (dim_bad || fifo_full || out_ovr);

   // mode sequencer: a start only takes effect at a frame boundary
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ITPSC_PASS;
      end else begin
         case (state)
            ITPSC_PASS: begin
               if (cfg_start || start_pend) begin
                  state <= ITPSC_ARM;
               end
            end
            ITPSC_ARM: begin
               if (frame_start) begin
                  state <= ITPSC_SYNC;
               end
            end
            ITPSC_SYNC: begin
               if (lose_sync) begin
                  state <= ITPSC_LOS;
               end
            end
            ITPSC_LOS: begin
               // recover by re-arming in the next cycle; sync returns on the next frame start
               state <= ITPSC_ARM;
            end
            default: begin
               state <= ITPSC_PASS;
            end
         endcase
      end
   end

   // start request held until the frame boundary that honours it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         start_pend <= 1'b0;
      end else if (sync_hit) begin
         start_pend <= 1'b0;
      end else if (cfg_start) begin
         start_pend <= 1'b1;
      end
   end

   // sync level on the pin and in the status, dropped on loss of sync
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync_pin    <= 1'b0;
         sync_status <= 1'b0;
      end else if (sync_hit) begin
         sync_pin    <= 1'b1;
         sync_status <= 1'b1;
      end else if (lose_sync) begin
         sync_pin    <= 1'b0;
         sync_status <= 1'b0;
      end
   end

   // one-cycle sync event for the interrupt logic outside
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync_event <= 1'b0;
      end else begin
         sync_event <= sync_hit;
      end
   end

   // motion mode change waits for a frame boundary while in sync;
   // the memory port is dropped at once on loss of sync
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         motion_pend <= 1'b0;
         mem_port_en <= 1'b0;
      end else begin
         if (cfg_motion != mem_port_en) begin
            motion_pend <= 1'b1;
         end
         if ((state == ITPSC_SYNC) && frame_start && motion_pend) begin
            mem_port_en <= cfg_motion;
            motion_pend <= 1'b0;
         end
         if (lose_sync) begin
            mem_port_en <= 1'b0;
         end
      end
   end

   // error events of this cycle
   always_comb begin
      err_set              = '0;
      err_set[ERR_IN_OVR]  = in_push && fifo_full && out_stalled;
      err_set[ERR_OUT_OVR] = out_ovr;
      err_set[ERR_LOS]     = lose_sync;
      err_set[ERR_WR_OVF]  = mem_wr_ovf && cfg_irq_en[ERR_WR_OVF];
      err_set[ERR_RD0_UDF] = mem_rd0_udf && cfg_irq_en[ERR_RD0_UDF];
      err_set[ERR_RD1_UDF] = mem_rd1_udf && cfg_irq_en[ERR_RD1_UDF];
   end

   // next flag word; a set in the same cycle as its clear wins
   assign next_err_status = (err_status & ~err_clear) | err_set;

   // sticky error flags
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         err_status <= ERR_RESET;
      end else begin
         err_status <= next_err_status;
      end
   end

   // interrupt from the enabled flags, stored in the same cycle as they are
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(next_err_status & cfg_irq_en);
      end
   end
endmodule

// ### tb/itpsc_checker_sva.sv
// port assertions for the sync control
module itpsc_checker
   import itpsc_pkg::*;
#(
   parameter int DATA_W = 24
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              s_tvalid,
   input wire logic              s_active,
   input wire logic              s_tready,
   input wire logic [DATA_W-1:0] m_tdata,
   input wire logic              m_tvalid,
   input wire logic              m_tready,
   input wire logic [ERR_W-1:0]  cfg_irq_en,
   input wire logic [ERR_W-1:0]  err_clear,
   input wire logic              mem_wr_ovf,
   input wire logic              sync_pin,
   input wire logic              sync_status,
   input wire logic              sync_event,
   input wire logic [ERR_W-1:0]  err_status,
   input wire logic              irq
);
   timeunit 1ns;
   timeprecision 1ps;
   int stall_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // current output stall length, capped so it never wraps
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         stall_cnt <= 0;
      else if (!m_tvalid || m_tready)
         stall_cnt <= 0;
      else if (stall_cnt < 2000)
         stall_cnt <= stall_cnt + 1;
   end
   hold_a: assert property (m_tvalid && !m_tready |=> m_tvalid && $stable(m_tdata))
      else $error("output word changed while stalled");
   blank_a: assert property (s_tvalid && !s_active |-> s_tready)
      else $error("blanking sample refused");
   pin_a: assert property (sync_pin == sync_status)
      else $error("sync pin and status differ");
   sync_pulse_a: assert property ($rose(sync_status) |-> sync_event ##1 !sync_event)
      else $error("sync event not a single pulse");
   wr_set_a: assert property (mem_wr_ovf && cfg_irq_en[ERR_WR_OVF] |=> err_status[ERR_WR_OVF])
      else $error("write overflow not flagged");
   clear_only_a: assert property ($fell(err_status[ERR_OUT_OVR]) |-> $past(err_clear[ERR_OUT_OVR]))
      else $error("error bit dropped without clear");
   irq_sum_a: assert property (1'b1 |=> irq == |(err_status & $past(cfg_irq_en)))
      else $error("irq does not follow enabled status");
   out_ovr_a: assert property (stall_cnt == 1008 |-> err_status[ERR_OUT_OVR])
      else $error("output overrun not flagged");
   cover property (sync_event);
   cover property ($rose(err_status[ERR_OUT_OVR]));
   cover property (m_tvalid && m_tready);
endmodule

bind itpsc_top itpsc_checker #(.DATA_W(DATA_W)) chk (.clk_sys, .rst, .s_tvalid, .s_active,
   .s_tready, .m_tdata, .m_tvalid, .m_tready, .cfg_irq_en, .err_clear, .mem_wr_ovf, .sync_pin,
   .sync_status, .sync_event, .err_status, .irq);

// ### tb/itpsc_sink.sv
// downstream stream model: prompt, slowed or stalled consumer
module itpsc_sink #(
   parameter int DATA_W = 24
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [DATA_W-1:0] m_tdata,
   input  wire logic              m_tvalid,
   input  wire logic              m_tuser,
   input  wire logic              m_tlast,
   input  wire logic              stall,
   input  wire logic              slow,
   output logic                   m_tready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W+1:0] rx[$];
   logic              tick;
   // slowed mode drops ready every other cycle, like a busy consumer
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         m_tready <= 1'b0;
         tick     <= 1'b0;
      end else begin
         if (m_tvalid && m_tready)
            rx.push_back({m_tdata, m_tuser, m_tlast});
         tick     <= !tick;
         m_tready <= !stall && (!slow || tick);
      end
   end
endmodule

// ### tb/testbench.sv
// self-checking bench for the sync control
module testbench
   import itpsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIFE = 20000;
   logic clk_sys = 0, rst = 1, stall = 0, slow = 0, ev_seen = 0;
   logic s_tvalid = 0, s_tuser = 0, s_tlast = 0, s_active = 0, s_tready;
   logic m_tvalid, m_tuser, m_tlast, m_tready, sync_pin, sync_status, sync_event;
   logic cfg_motion = 0, cfg_start = 0, mem_port_en, irq;
   logic [23:0] s_tdata = '0, m_tdata;
   logic [DIM_W-1:0] cfg_width = '0, cfg_height = '0;
   logic [ERR_W-1:0] cfg_irq_en = '0, err_clear = '0, err_status;
   logic [2:0] mem_ev = '0;
   int fail_count = 0, checked = 0, cyc = 0;
   itpsc_top #(.EVAL_BUILD(1'b1), .EVAL_LIMIT(LIFE)) dut (.clk_sys, .rst, .s_tdata, .s_tvalid,
      .s_tuser, .s_tlast, .s_active, .s_tready, .m_tdata, .m_tvalid, .m_tuser, .m_tlast,
      .m_tready, .cfg_width, .cfg_height, .cfg_motion, .cfg_start, .cfg_irq_en, .err_clear,
      .mem_wr_ovf(mem_ev[0]), .mem_rd0_udf(mem_ev[1]), .mem_rd1_udf(mem_ev[2]), .sync_pin,
      .sync_status, .sync_event, .mem_port_en, .err_status, .irq);
   itpsc_sink snk (.clk_sys, .rst, .m_tdata, .m_tvalid, .m_tuser, .m_tlast, .stall, .slow,
      .m_tready);
   always #5 clk_sys = ~clk_sys;
   // sync pulse is a single cycle, so latch it for later checks
   always @(posedge clk_sys) begin
      cyc++;
      if (sync_event === 1'b1)
         ev_seen <= 1'b1;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask
   // valid stays up after a take so back-to-back samples need no extra edge
   task automatic send(input logic [23:0] d, input logic u, l, a);
      s_tdata = d;
      s_tuser = u;
      s_tlast = l;
      s_active = a;
      s_tvalid = 1;
      #1;
      for (int n = 0; s_tready !== 1'b1 && n < 2000; n++)
         @(negedge clk_sys) #1;
      @(negedge clk_sys);
   endtask
   // active samples carry {line, column}; one blanking sample per line
   task automatic frame(input int w, h);
      for (int y = 0; y < h; y++) begin
         for (int x = 0; x < w; x++)
            send({12'(y), 12'(x)}, x == 0 && y == 0, x == w - 1, 1'b1);
         send(24'h00_0000, 1'b0, 1'b0, 1'b0);
      end
      s_tvalid = 0;
      repeat (40) @(negedge clk_sys);
   endtask
   task automatic check_rx(input int w, h, c);
      int k;
      chk("word count", w * h * c, snk.rx.size());
      foreach (snk.rx[j]) begin
         k = j / c;
         chk("out word", {12'(k / w), 12'(k % w), j == 0, k % w == w - 1 && j % c == c - 1},
            snk.rx[j]);
      end
      snk.rx.delete();
   endtask
   task automatic t_pass();
      slow = 1;
      frame(3, 2);
      slow = 0;
      check_rx(3, 2, 1);
      chk("mem port idle", 0, mem_port_en);
   endtask
   task automatic t_overrun();
      stall = 1;
      cfg_irq_en = 12'h002;
      send(24'h00_0abc, 1'b0, 1'b0, 1'b1);
      repeat (10) @(negedge clk_sys);
      chk("in overrun", 1, err_status[ERR_IN_OVR]);
      chk("irq masked", 0, irq);
      s_tvalid = 0;
      repeat (985) @(negedge clk_sys);
      chk("out overrun early", 0, err_status[ERR_OUT_OVR]);
      repeat (20) @(negedge clk_sys);
      chk("out overrun", 1, err_status[ERR_OUT_OVR]);
      chk("irq raised", 1, irq);
      stall = 0;
      repeat (20) @(negedge clk_sys);
      chk("sticky bits", 12'h003, err_status);
      err_clear = 12'h003;
      @(negedge clk_sys);
      err_clear = 12'h000;
      @(negedge clk_sys);
      chk("bits cleared", 0, err_status);
      chk("irq cleared", 0, irq);
      snk.rx.delete();
   endtask
   task automatic t_sync();
      cfg_width = 12'h002;
      cfg_height = 12'h002;
      cfg_start = 1;
      @(negedge clk_sys);
      cfg_start = 0;
      send(24'h00_0012, 1'b0, 1'b1, 1'b1);
      s_tvalid = 0;
      repeat (5) @(negedge clk_sys);
      chk("sync before frame", 0, sync_pin);
      snk.rx.delete();
      frame(2, 2);
      chk("sync pin", 1, sync_pin);
      chk("sync event", 1, ev_seen);
      check_rx(2, 2, 2);
      cfg_motion = 1;
      repeat (5) @(negedge clk_sys);
      chk("mem port early", 0, mem_port_en);
      frame(2, 2);
      chk("mem port", 1, mem_port_en);
      snk.rx.delete();
   endtask
   task automatic t_lost();
      frame(3, 2);
      chk("lost flag", 1, err_status[ERR_LOS]);
      chk("lost status", 0, sync_status);
      snk.rx.delete();
   endtask
   task automatic t_mem();
      for (int i = 0; i < 3; i++) begin
         for (int e = 0; e < 2; e++) begin
            cfg_irq_en = 12'(e) << (ERR_WR_OVF + i);
            mem_ev = 3'(1 << i);
            @(negedge clk_sys);
            mem_ev = 3'h0;
            @(negedge clk_sys);
            chk("mem errors", e << i, err_status[11:9]);
            @(negedge clk_sys);
            chk("mem irq", e, irq);
            err_clear = 12'he00;
            @(negedge clk_sys);
            err_clear = 12'h000;
         end
      end
   endtask
   task automatic t_eval();
      while (cyc < LIFE + 40)
         @(negedge clk_sys);
      send(24'h00_00a5, 1'b0, 1'b0, 1'b1);
      s_tvalid = 0;
      repeat (10) @(negedge clk_sys);
      chk("late output", 1, snk.rx.size() > 0);
      foreach (snk.rx[j])
         chk("forced zero", 0, snk.rx[j][25:2]);
   endtask
   task automatic complete_run();
      if (fail_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // whole run is about 20k cycles; reaching 45k cycles means a hang
   initial begin
      #450us;
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 0;
      @(negedge clk_sys);
      t_pass();
      t_overrun();
      t_sync();
      t_lost();
      t_mem();
      t_eval();
      complete_run();
   end
endmodule
